// *** src/servo_fault_supervisor.sv ***
// Fault supervisor for a servo drive: watches motion quantities and pins, latches faults,
// reports them over APB and raises one level interrupt.
// Assumes same-clock inputs from the motion core and raw, asynchronous terminal pins.
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns

module servo_fault_supervisor
    import servo_fault_pkg::*;
#(
    parameter int TICK_CYCLES = CYCLES_PER_TICK,
    parameter int DATA_W = 32
) (
    input wire logic clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Motion core, same clock
    input wire logic [DATA_W-1:0] multi_turn_count_value,
    input wire logic [DATA_W-1:0] position_error,
    input wire logic [DATA_W-1:0] external_encoder_position,
    input wire logic [DATA_W-1:0] motor_encoder_position,
    input wire logic internal_command_source,
    input wire logic motion_active,
    input wire logic can_frame_received,
    input wire logic homing_enable,
    input wire logic home_found,
    // Terminal pins, asynchronous
    input wire logic command_pulse_pin,
    input wire logic positive_limit_pin,
    input wire logic negative_limit_pin,
    input wire logic external_fault_pin,
    // Status
    output logic fault_active,
    output logic [7:0] fault_code,
    output logic irq
);

    // Register file
    logic [CTRL_WIDTH-1:0] ctrl_ff;
    logic [31:0] position_deviation_limit_ff;
    logic [31:0] max_pulse_frequency_ff;
    logic [31:0] closed_loop_deviation_threshold_ff;
    logic [31:0] can_disconnect_timeout_ff;
    logic [31:0] homing_timeout_ff;
    logic [NUM_FAULTS-1:0] irq_mask_ff;
    logic [NUM_FAULTS-1:0] irq_status_ff;
    logic [NUM_FAULTS-1:0] fault_latch_ff;
    logic fault_reset_ff;

    logic [1:0] closed_loop_feedback_mode;
    logic [1:0] overtravel_handling_select;
    assign closed_loop_feedback_mode = ctrl_ff[CTRL_FB_MODE_LO +: 2];
    assign overtravel_handling_select = ctrl_ff[CTRL_OT_SEL_LO +: 2];

    // APB decode: zero wait states
    logic wr_en;
    logic rd_en;
    logic addr_hit;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;

    always_comb begin
        addr_hit = 1'b1;
        unique case (paddr)
            OFS_CTRL, OFS_POS_DEV_LIMIT, OFS_MAX_PULSE_FREQ, OFS_CL_DEV_THRESH,
            OFS_CAN_TIMEOUT, OFS_HOMING_TIMEOUT, OFS_FAULT_LATCH, OFS_FAULT_CODE,
            OFS_IRQ_STATUS, OFS_IRQ_MASK, OFS_MULTI_TURN: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !addr_hit;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_ff <= CTRL_RESET;
            position_deviation_limit_ff <= POS_DEV_LIMIT_RESET;
            max_pulse_frequency_ff <= MAX_PULSE_FREQ_RESET;
            closed_loop_deviation_threshold_ff <= CL_DEV_THRESH_RESET;
            can_disconnect_timeout_ff <= CAN_TIMEOUT_RESET;
            homing_timeout_ff <= HOMING_TIMEOUT_RESET;
            irq_mask_ff <= '0;
        end else if (wr_en) begin
            unique case (paddr)
                OFS_CTRL: ctrl_ff <= pwdata[CTRL_WIDTH-1:0] & ~CTRL_WIDTH'(1 << CTRL_FAULT_RESET);
                OFS_POS_DEV_LIMIT: position_deviation_limit_ff <= pwdata;
                OFS_MAX_PULSE_FREQ: max_pulse_frequency_ff <= pwdata;
                OFS_CL_DEV_THRESH: closed_loop_deviation_threshold_ff <= pwdata;
                OFS_CAN_TIMEOUT: can_disconnect_timeout_ff <= pwdata;
                OFS_HOMING_TIMEOUT: homing_timeout_ff <= pwdata;
                OFS_IRQ_MASK: irq_mask_ff <= pwdata[NUM_FAULTS-1:0];
                default: ;
            endcase
        end
    end

    // Fault reset request, one-cycle pulse
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fault_reset_ff <= 1'b0;
        end else begin
            fault_reset_ff <= wr_en && paddr == OFS_CTRL && pwdata[CTRL_FAULT_RESET];
        end
    end

    // Pin synchronisers
    logic [NUM_PINS-1:0] pin_raw;
    logic [NUM_PINS-1:0] pin_meta_ff;
    logic [NUM_PINS-1:0] pin_sync_ff;
    assign pin_raw = {external_fault_pin, negative_limit_pin, positive_limit_pin,
        command_pulse_pin};

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_sync
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    pin_meta_ff[gi] <= 1'b0;
                    pin_sync_ff[gi] <= 1'b0;
                end else begin
                    pin_meta_ff[gi] <= pin_raw[gi];
                    pin_sync_ff[gi] <= pin_meta_ff[gi];
                end
            end
        end
    endgenerate

    // Millisecond tick
    logic [31:0] tick_cnt_ff;
    logic tick;
    assign tick = tick_cnt_ff == 32'(TICK_CYCLES - 1);

    always_ff @(posedge clk) begin
        if (sys_rst || tick) begin
            tick_cnt_ff <= '0;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h1;
        end
    end

    // Command pulse rate: rising edges counted per tick window
    logic pulse_prev_ff;
    logic [31:0] pulse_cnt_ff;
    logic pulse_edge;
    logic pulse_over_ff;
    assign pulse_edge = pin_sync_ff[PIN_PULSE] && !pulse_prev_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pulse_prev_ff <= 1'b0;
        end else begin
            pulse_prev_ff <= pin_sync_ff[PIN_PULSE];
        end
    end

    // Saturates so a runaway pin cannot wrap below the limit
    always_ff @(posedge clk) begin
        if (sys_rst || tick) begin
            pulse_cnt_ff <= '0;
        end else if (pulse_edge && pulse_cnt_ff != 32'hffffffff) begin
            pulse_cnt_ff <= pulse_cnt_ff + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pulse_over_ff <= 1'b0;
        end else begin
            pulse_over_ff <= pulse_cnt_ff > max_pulse_frequency_ff;
        end
    end

    // Magnitudes of the two deviations
    // Both signed inputs, compared as unsigned magnitudes
    logic [DATA_W-1:0] pos_err_abs;
    logic [DATA_W-1:0] enc_diff;
    logic [DATA_W-1:0] enc_diff_abs;
    assign pos_err_abs = position_error[DATA_W-1] ? DATA_W'(-position_error) : position_error;
    assign enc_diff = external_encoder_position - motor_encoder_position;
    assign enc_diff_abs = enc_diff[DATA_W-1] ? DATA_W'(-enc_diff) : enc_diff;

    // Silence counter saturates, so a long outage never wraps to zero
    // CAN silence timer
    logic [31:0] can_quiet_ff;
    always_ff @(posedge clk) begin
        if (sys_rst || can_frame_received) begin
            can_quiet_ff <= '0;
        end else if (tick && can_quiet_ff != 32'hffffffff) begin
            can_quiet_ff <= can_quiet_ff + 32'h1;
        end
    end

    logic [31:0] homing_cnt_ff;
    always_ff @(posedge clk) begin
        if (sys_rst || !homing_enable || home_found) begin
            homing_cnt_ff <= '0;
        end else if (tick && homing_cnt_ff != 32'hffffffff) begin
            homing_cnt_ff <= homing_cnt_ff + 32'h1;
        end
    end

    // Fault causes
    logic [NUM_FAULTS-1:0] cause;
    logic overtravel_faults;
    assign overtravel_faults = overtravel_handling_select == OT_SEL_FAULT && motion_active;

    always_comb begin
        cause = '0;
        cause[F_MULTI_TURN] = DATA_W'(multi_turn_count_value) > MULTI_TURN_MAX
            && !ctrl_ff[CTRL_MT_MASK];
        cause[F_POS_DEV] = pos_err_abs > position_deviation_limit_ff;
        cause[F_PULSE_FREQ] = pulse_over_ff;
        cause[F_CL_DEV] = ctrl_ff[CTRL_CL_ENABLE]
            && enc_diff_abs > closed_loop_deviation_threshold_ff;
        cause[F_CL_CONFIG] = ctrl_ff[CTRL_CL_ENABLE] && internal_command_source
            && (closed_loop_feedback_mode == FB_MODE_SWITCHING
            || closed_loop_feedback_mode != FB_MODE_EXTERNAL);
        cause[F_CAN_LOST] = can_disconnect_timeout_ff != '0
            && can_quiet_ff > can_disconnect_timeout_ff;
        cause[F_HOMING] = homing_enable && !home_found
            && homing_cnt_ff > homing_timeout_ff;
        cause[F_POS_LIMIT] = overtravel_faults && pin_sync_ff[PIN_POS_LIMIT];
        cause[F_NEG_LIMIT] = overtravel_faults && pin_sync_ff[PIN_NEG_LIMIT];
        cause[F_EXT_FAULT] = pin_sync_ff[PIN_EXT_FAULT];
    end

    // latch until reset with cause gone
    logic [NUM_FAULTS-1:0] nxt_fault_latch;
    logic [NUM_FAULTS-1:0] new_fault;
    assign new_fault = cause & ~fault_latch_ff;
    assign nxt_fault_latch = fault_reset_ff ? cause : (fault_latch_ff | cause);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fault_latch_ff <= '0;
        end else begin
            fault_latch_ff <= nxt_fault_latch;
        end
    end

    // Interrupt status: read clears, a new fault wins over the clear
    logic irq_status_read;
    assign irq_status_read = rd_en && paddr == OFS_IRQ_STATUS;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_status_ff <= '0;
        end else if (irq_status_read) begin
            irq_status_ff <= new_fault;
        end else begin
            irq_status_ff <= irq_status_ff | new_fault;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_ff & irq_mask_ff);
        end
    end

    // Lowest-numbered latched fault is reported
    logic [7:0] nxt_fault_code;
    always_comb begin
        nxt_fault_code = 8'h00;
        for (int i = NUM_FAULTS - 1; i >= 0; i--) begin
            if (fault_latch_ff[i]) begin
                nxt_fault_code = FAULT_CODES[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fault_code <= 8'h00;
            fault_active <= 1'b0;
        end else begin
            fault_code <= nxt_fault_code;
            fault_active <= |fault_latch_ff;
        end
    end

    // APB read data
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        unique case (paddr)
            OFS_CTRL: rd_mux = 32'(ctrl_ff);
            OFS_POS_DEV_LIMIT: rd_mux = position_deviation_limit_ff;
            OFS_MAX_PULSE_FREQ: rd_mux = max_pulse_frequency_ff;
            OFS_CL_DEV_THRESH: rd_mux = closed_loop_deviation_threshold_ff;
            OFS_CAN_TIMEOUT: rd_mux = can_disconnect_timeout_ff;
            OFS_HOMING_TIMEOUT: rd_mux = homing_timeout_ff;
            OFS_FAULT_LATCH: rd_mux = 32'(fault_latch_ff);
            OFS_FAULT_CODE: rd_mux = 32'(fault_code);
            OFS_IRQ_STATUS: rd_mux = 32'(irq_status_ff);
            OFS_IRQ_MASK: rd_mux = 32'(irq_mask_ff);
            OFS_MULTI_TURN: rd_mux = 32'(multi_turn_count_value);
            default: rd_mux = '0;
        endcase
    end

    // Read data is combinational from registers, valid in the access phase
    assign prdata = rd_en ? rd_mux : 32'h0;

endmodule

// *** src/servo_fault_pkg.sv ***
// Constants shared by the servo fault supervisor: register map, fault bits and codes.
// Assumes a 250 MHz system clock and a 32-bit APB register bus.
package servo_fault_pkg;

    // Clock and time base
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int CYCLES_PER_TICK = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_POS_DEV_LIMIT = 8'h04;
    localparam logic [7:0] OFS_MAX_PULSE_FREQ = 8'h08;
    localparam logic [7:0] OFS_CL_DEV_THRESH = 8'h0c;
    localparam logic [7:0] OFS_CAN_TIMEOUT = 8'h10;
    localparam logic [7:0] OFS_HOMING_TIMEOUT = 8'h14;
    localparam logic [7:0] OFS_FAULT_LATCH = 8'h18;
    localparam logic [7:0] OFS_FAULT_CODE = 8'h1c;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
    localparam logic [7:0] OFS_MULTI_TURN = 8'h28;

    // Control register fields
    localparam int CTRL_FAULT_RESET = 0;
    localparam int CTRL_CL_ENABLE = 1;
    localparam int CTRL_MT_MASK = 2;
    localparam int CTRL_FB_MODE_LO = 4;
    localparam int CTRL_OT_SEL_LO = 6;
    localparam int CTRL_WIDTH = 8;

    // Field values
    localparam logic [1:0] FB_MODE_EXTERNAL = 2'h1;
    localparam logic [1:0] FB_MODE_SWITCHING = 2'h2;
    localparam logic [1:0] OT_SEL_FAULT = 2'h0;
    localparam logic [31:0] MULTI_TURN_MAX = 32'h0000ffff;

    // Reset values
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 8'h10;
    localparam logic [31:0] POS_DEV_LIMIT_RESET = 32'h00010000;
    localparam logic [31:0] MAX_PULSE_FREQ_RESET = 32'h00000fa0;
    localparam logic [31:0] CL_DEV_THRESH_RESET = 32'h00010000;
    localparam logic [31:0] CAN_TIMEOUT_RESET = 32'h00000000;
    localparam logic [31:0] HOMING_TIMEOUT_RESET = 32'h00002710;

    // Fault bit positions
    localparam int NUM_FAULTS = 10;
    localparam int F_MULTI_TURN = 0;
    localparam int F_POS_DEV = 1;
    localparam int F_PULSE_FREQ = 2;
    localparam int F_CL_DEV = 3;
    localparam int F_CL_CONFIG = 4;
    localparam int F_CAN_LOST = 5;
    localparam int F_HOMING = 6;
    localparam int F_POS_LIMIT = 7;
    localparam int F_NEG_LIMIT = 8;
    localparam int F_EXT_FAULT = 9;

    // Fault codes, indexed by fault bit
    localparam logic [7:0] FAULT_CODES [NUM_FAULTS] = '{
        8'h1f, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h27, 8'h28, 8'h2b
    };

    // Pins passed through the synchroniser
    localparam int NUM_PINS = 4;
    localparam int PIN_PULSE = 0;
    localparam int PIN_POS_LIMIT = 1;
    localparam int PIN_NEG_LIMIT = 2;
    localparam int PIN_EXT_FAULT = 3;

endpackage

// *** verification/servo_fault_supervisor_chk.sv ***
// Checker for the servo fault supervisor: bus replies and fault latching.
// Sees only the top module's ports; bound in below.
`timescale 1ns/1ns
module servo_fault_supervisor_chk
    import servo_fault_pkg::*;
#(
    parameter int DATA_W = 32
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [DATA_W-1:0] multi_turn_count_value,
    input wire logic external_fault_pin,
    input wire logic fault_active,
    input wire logic [7:0] fault_code,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire logic acc = psel && penable;
    wire logic rst_wr = acc && pwrite && paddr == OFS_CTRL && pwdata[CTRL_FAULT_RESET];

    ready_ok_a: assert property (pready)
        else $error("pready low");
    slverr_map_a: assert property (acc |-> pslverr == (paddr > 8'h28 || paddr[1:0] != 2'h0))
        else $error("slave error wrong");
    slverr_idle_a: assert property (!acc |-> !pslverr)
        else $error("slave error outside access");
    rdata_idle_a: assert property (!(acc && !pwrite) |-> prdata == 32'h0)
        else $error("read data not zero");
    mt_read_a: assert property (acc && !pwrite && paddr == OFS_MULTI_TURN |->
        prdata == multi_turn_count_value) else $error("turn count read wrong");
    ext_fault_a: assert property (external_fault_pin [*4] |=> fault_active)
        else $error("external fault missed");
    latch_hold_a: assert property (fault_active && !rst_wr && !$past(rst_wr)
        && !$past(rst_wr, 2) |=> fault_active) else $error("fault dropped");
    code_valid_a: assert property (fault_active |-> fault_code inside
        {8'h1f, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h27, 8'h28, 8'h2b})
        else $error("bad fault code");
    code_active_a: assert property (fault_active == (fault_code != 8'h0))
        else $error("code and active disagree");

    cover property (rst_wr && fault_active);
    cover property (acc && pslverr);
    cover property ($rose(irq));
endmodule

bind servo_fault_supervisor servo_fault_supervisor_chk #(.DATA_W(DATA_W)) u_chk (.clk, .sys_rst,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .multi_turn_count_value, .external_fault_pin, .fault_active, .fault_code, .irq);

// *** verification/servo_host_model.sv ***
// Host pulse source and CAN master feeding the supervisor.
// Same clock as the block; pulse pin idles low.
`timescale 1ns/1ns
module servo_host_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic pulse_on,
    input wire logic can_on,
    output logic command_pulse_pin,
    output logic can_frame_received
);
    logic [7:0] pcnt_ff;
    logic [7:0] ccnt_ff;
    always_ff @(posedge clk) begin
        pcnt_ff <= sys_rst ? 8'h0 : pcnt_ff + 8'h1;
        if (sys_rst || !pulse_on)
            command_pulse_pin <= 1'b0;
        else if (pcnt_ff[4:0] == 5'h1f)
            command_pulse_pin <= !command_pulse_pin;
    end
    always_ff @(posedge clk) begin
        ccnt_ff <= (sys_rst || ccnt_ff == 8'h63) ? 8'h0 : ccnt_ff + 8'h1;
        can_frame_received <= !sys_rst && can_on && ccnt_ff == 8'h63;
    end
endmodule

// *** verification/servo_fault_supervisor_tb.sv ***
// Self-checking bench for the servo fault supervisor.
// Drives APB and motion inputs; host model supplies pulses and CAN frames.
`timescale 1ns/1ns
module servo_fault_supervisor_tb;
    import servo_fault_pkg::*;
    logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 0, prdata, rd, ctrl = 32'h10;
    logic pready, pslverr, fault_active, irq, command_pulse_pin, can_frame_received;
    logic [7:0] fault_code;
    logic [31:0] multi_turn_count_value = 0, position_error = 0;
    logic [31:0] external_encoder_position = 0, motor_encoder_position = 0;
    logic internal_command_source = 0, motion_active = 0, homing_enable = 0, home_found = 0;
    logic positive_limit_pin = 0, negative_limit_pin = 0, external_fault_pin = 0;
    logic pulse_on = 0, can_on = 0;
    int errors = 0, n_tests = 0, cyc = 0;

    servo_fault_supervisor #(.TICK_CYCLES(200)) dut (.clk, .sys_rst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .multi_turn_count_value,
        .position_error, .external_encoder_position, .motor_encoder_position,
        .internal_command_source, .motion_active, .can_frame_received, .homing_enable,
        .home_found, .command_pulse_pin, .positive_limit_pin, .negative_limit_pin,
        .external_fault_pin, .fault_active, .fault_code, .irq);
    servo_host_model host (.clk, .sys_rst, .pulse_on, .can_on, .command_pulse_pin,
        .can_frame_received);

    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            summarize();
        end
    end

    task summarize;
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %0t saw %h want %h", $time, s, e);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task setc(input logic [31:0] v);
        ctrl = v;
        apb(1'b1, OFS_CTRL, v);
    endtask
    task clr;
        apb(1'b1, OFS_CTRL, ctrl | 32'h1);
        wt(4);
    endtask

    task t_regs;
        rdchk(OFS_CTRL, 32'h10);
        rdchk(OFS_POS_DEV_LIMIT, POS_DEV_LIMIT_RESET);
        rdchk(OFS_MAX_PULSE_FREQ, MAX_PULSE_FREQ_RESET);
        rdchk(OFS_CL_DEV_THRESH, CL_DEV_THRESH_RESET);
        rdchk(OFS_CAN_TIMEOUT, CAN_TIMEOUT_RESET);
        rdchk(OFS_HOMING_TIMEOUT, HOMING_TIMEOUT_RESET);
        rdchk(OFS_IRQ_MASK, 32'h0);
        apb(1'b1, OFS_FAULT_LATCH, 32'hffff);
        rdchk(OFS_FAULT_LATCH, 32'h0);
        rdchk(8'h2c, 32'h0);
        apb(1'b1, OFS_IRQ_MASK, 32'h3ff);
        rdchk(OFS_IRQ_MASK, 32'h3ff);
    endtask
    task t_ext;
        external_fault_pin <= 1'b1;
        wt(6);
        chk(fault_code, 8'h2b);
        chk(irq, 1'b1);
        clr;
        chk(fault_code, 8'h2b);
        external_fault_pin <= 1'b0;
        wt(4);
        chk(fault_code, 8'h2b);
        clr;
        chk(fault_code, 8'h0);
        rdchk(OFS_IRQ_STATUS, 32'h200);
        rdchk(OFS_IRQ_STATUS, 32'h0);
        wt(2);
        chk(irq, 1'b0);
    endtask
    task t_mt;
        multi_turn_count_value <= 32'hffff;
        wt(4);
        chk(fault_code, 8'h0);
        multi_turn_count_value <= 32'h10000;
        wt(4);
        chk(fault_code, 8'h1f);
        setc(32'h14);
        clr;
        chk(fault_code, 8'h0);
        multi_turn_count_value <= 32'h0;
        setc(32'h10);
    endtask
    task t_pos;
        position_error <= POS_DEV_LIMIT_RESET;
        wt(4);
        chk(fault_code, 8'h0);
        position_error <= POS_DEV_LIMIT_RESET + 32'h1;
        wt(4);
        chk(fault_code, 8'h20);
        position_error <= 32'h0;
        clr;
        chk(fault_code, 8'h0);
    endtask
    task t_pulse;
        apb(1'b1, OFS_MAX_PULSE_FREQ, 32'h1);
        pulse_on <= 1'b1;
        wt(700);
        chk(fault_code, 8'h21);
        apb(1'b1, OFS_MAX_PULSE_FREQ, MAX_PULSE_FREQ_RESET);
        clr;
        wt(700);
        chk(fault_code, 8'h0);
        pulse_on <= 1'b0;
    endtask
    task t_cl;
        internal_command_source <= 1'b1;
        setc(32'h12);
        wt(4);
        chk(fault_code, 8'h0);
        setc(32'h22);
        wt(4);
        chk(fault_code, 8'h23);
        setc(32'h12);
        clr;
        external_encoder_position <= 32'h10001;
        wt(4);
        chk(fault_code, 8'h22);
        external_encoder_position <= 32'h0;
        clr;
        chk(fault_code, 8'h0);
        setc(32'h10);
        internal_command_source <= 1'b0;
    endtask
    task t_can;
        can_on <= 1'b1;
        wt(200);
        apb(1'b1, OFS_CAN_TIMEOUT, 32'h2);
        wt(1000);
        chk(fault_code, 8'h0);
        can_on <= 1'b0;
        wt(1000);
        chk(fault_code, 8'h24);
        apb(1'b1, OFS_CAN_TIMEOUT, 32'h0);
        clr;
    endtask
    task t_home;
        apb(1'b1, OFS_HOMING_TIMEOUT, 32'h3);
        homing_enable <= 1'b1;
        wt(400);
        chk(fault_code, 8'h0);
        wt(600);
        chk(fault_code, 8'h25);
        home_found <= 1'b1;
        clr;
        chk(fault_code, 8'h0);
        homing_enable <= 1'b0;
    endtask
    task t_lim;
        motion_active <= 1'b1;
        positive_limit_pin <= 1'b1;
        wt(6);
        chk(fault_code, 8'h27);
        positive_limit_pin <= 1'b0;
        clr;
        negative_limit_pin <= 1'b1;
        wt(6);
        chk(fault_code, 8'h28);
        negative_limit_pin <= 1'b0;
        clr;
        setc(32'h50);
        positive_limit_pin <= 1'b1;
        wt(6);
        chk(fault_code, 8'h0);
        positive_limit_pin <= 1'b0;
        motion_active <= 1'b0;
    endtask

    initial begin
        wt(8);
        sys_rst <= 1'b0;
        t_regs;
        t_ext;
        t_mt;
        t_pos;
        t_pulse;
        t_cl;
        t_can;
        t_home;
        t_lim;
        summarize();
    end
endmodule
